// File: core/tss_pkg.sv
// shared constants and types for the thermal sensor smbus slave
package tss_pkg;
  // ----------
  // bus identity and command codes
  // ----------
  localparam logic [6:0] SLAVE_ADDR = 7'h4c; // binary 1001100
  localparam logic [7:0] CMD_LOCAL = 8'h00;
  localparam logic [7:0] CMD_RHB = 8'h01;
  localparam logic [7:0] CMD_STAT = 8'h02;
  localparam logic [7:0] CMD_CFG_RD = 8'h03;
  localparam logic [7:0] CMD_RATE_RD = 8'h04;
  localparam logic [7:0] CMD_LHS_RD = 8'h05;
  localparam logic [7:0] CMD_LLS_RD = 8'h06;
  localparam logic [7:0] CMD_RHS_RD = 8'h07;
  localparam logic [7:0] CMD_RLS_RD = 8'h08;
  localparam logic [7:0] CMD_CFG_WR = 8'h09;
  localparam logic [7:0] CMD_RATE_WR = 8'h0a;
  localparam logic [7:0] CMD_LHS_WR = 8'h0b;
  localparam logic [7:0] CMD_LLS_WR = 8'h0c;
  localparam logic [7:0] CMD_RHS_WR = 8'h0d;
  localparam logic [7:0] CMD_RLS_WR = 8'h0e;
  localparam logic [7:0] CMD_ONESHOT = 8'h0f;
  localparam logic [7:0] CMD_RLB = 8'h10;
  localparam logic [7:0] CMD_RCS = 8'h19;
  localparam logic [7:0] CMD_LCS = 8'h20;
  localparam logic [7:0] CMD_FILT = 8'hbf;
  localparam logic [7:0] CMD_MFG_ID = 8'hfe;
  localparam logic [7:0] CMD_DIE_REV = 8'hff;
  // ----------
  // power-up values and fault codes
  // ----------
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h08;
  localparam logic [7:0] CRIT_RST = 8'h55;
  localparam logic [7:0] HIGH_RST = 8'h46;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] OPEN_HB = 8'h7f;
  localparam logic [7:0] SHORT_HB = 8'h80;
  localparam logic [7:0] FAULT_LB = 8'h00;
  // ----------
  // field positions and widths
  // ----------
  localparam int CFG_ALERT_MASK_BIT = 7;
  localparam int FILT_SEL_LO = 1;
  localparam int FILT_SEL_HI = 2;
  localparam int ST_BUSY = 7;
  localparam int ST_LHIGH = 6;
  localparam int ST_LLOW = 5;
  localparam int ST_RHIGH = 4;
  localparam int ST_RLOW = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_RCRIT = 1;
  localparam int ST_LCRIT = 0;
  localparam logic [7:0] ALERT_SRC_MASK = 8'h7b; // all flags but busy and open
  localparam int REM_W = 11;
  localparam int FRAC_PAD = 5;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_LVL2 = 2'h3;
  localparam int FILT_DEPTH = 8;
  localparam int FILT_L1_SHIFT = 2;
  localparam int FILT_L2_SHIFT = 3;
  // ----------
  // timing
  // ----------
  localparam int TIMEOUT_US = 35000;
  localparam int LINK_PERIOD_NS = 160;
  localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / LINK_PERIOD_NS;
  localparam int TO_W = 18;
  // ----------
  // types
  // ----------
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] lhs;
    logic [7:0] lls;
    logic [7:0] rhs;
    logic [7:0] rls;
    logic [7:0] remote_critical_limit;
    logic [7:0] lcs;
    logic [7:0] filt;
  } tss_regs_t;
  localparam tss_regs_t REGS_RST = '{cfg: CFG_RST, rate: RATE_RST, lhs: HIGH_RST,
    lls: LOW_RST, rhs: HIGH_RST, rls: LOW_RST, remote_critical_limit: CRIT_RST, lcs: CRIT_RST,
    filt: FILT_RST};
  typedef struct packed {
    logic [7:0] local_t;
    logic [7:0] rem_hb;
    logic [7:0] rem_lb;
    logic open;
  } tss_res_t;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_CMD = 8'h04,
    ST_WDATA = 8'h08,
    ST_ACK = 8'h10,
    ST_RDATA = 8'h20,
    ST_HACK = 8'h40,
    ST_WAIT = 8'h80
  } tss_state_t;
endpackage

// File: core/tss_filter.sv
// moving-average filter for remote diode samples
`timescale 1ns/10ps
module tss_filter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // sample in
  input wire logic sample_vld_in,
  input wire logic [tss_pkg::REM_W-1:0] sample_in,
  input wire logic [1:0] level_in,
  // averaged sample out
  output logic avg_vld_out,
  output logic [tss_pkg::REM_W-1:0] avg_out
);
  import tss_pkg::*;

  // ----------
  // history and output state
  // ----------
  logic [REM_W-1:0] hist_q [FILT_DEPTH]; // newest sample at index 0
  logic [REM_W-1:0] hist_d [FILT_DEPTH];
  logic filled_q; // history primed with a real sample
  logic filled_d;
  logic vld_q;
  logic vld_d;
  logic [REM_W-1:0] avg_q;
  logic [REM_W-1:0] avg_d;

  // shift register; first sample fills every slot so no start-up ramp
  genvar gi;
  generate
    for (gi = 0; gi < FILT_DEPTH; gi++) begin : g_hist
      always_comb begin
        if (!sample_vld_in) begin
          hist_d[gi] = hist_q[gi];
        end else if (gi == 0 || !filled_q) begin
          hist_d[gi] = sample_in;
        end else begin
          hist_d[gi] = hist_q[(gi > 0) ? gi-1 : 0];
        end
      end
    end
  endgenerate

  // windowed sums; level 2 uses the longer window
  always_comb begin
    logic signed [REM_W+FILT_L2_SHIFT-1:0] sum4;
    logic signed [REM_W+FILT_L2_SHIFT-1:0] sum8;
    logic signed [REM_W+FILT_L2_SHIFT-1:0] tmp;
    sum4 = '0;
    sum8 = '0;
    tmp = '0;
    for (int i = 0; i < FILT_DEPTH; i++) begin
      sum8 = sum8 + (REM_W+FILT_L2_SHIFT)'($signed(hist_d[i]));
      if (i < (1 << FILT_L1_SHIFT)) begin
        sum4 = sum4 + (REM_W+FILT_L2_SHIFT)'($signed(hist_d[i]));
      end
    end
    // exact division of a steady input, so no offset is added
    if (level_in == FILT_NONE) begin
      avg_d = sample_in;
    end else if (level_in == FILT_LVL2) begin
      tmp = sum8 >>> FILT_L2_SHIFT;
      avg_d = tmp[REM_W-1:0];
    end else begin
      tmp = sum4 >>> FILT_L1_SHIFT;
      avg_d = tmp[REM_W-1:0];
    end
    if (!sample_vld_in) begin
      avg_d = avg_q;
    end
    vld_d = sample_vld_in;
    filled_d = filled_q | sample_vld_in;
  end

  // registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < FILT_DEPTH; i++) begin
        hist_q[i] <= '0;
      end
      filled_q <= 1'b0;
      vld_q <= 1'b0;
      avg_q <= '0;
    end else begin
      hist_q <= hist_d;
      filled_q <= filled_d;
      vld_q <= vld_d;
      avg_q <= avg_d;
    end
  end

  assign avg_vld_out = vld_q;
  assign avg_out = avg_q;
endmodule

// File: core/tss_slave.sv
// smbus slave front end and result path of the thermal sensor
//
// Overview of operation
// - pointer, status, configuration reset to zero
// - setpoints reset to 85, 70, 0
// - filter and alert configuration resets zero
// - conversion rate resets to eight
// - results read zero until first conversion
// - slave only, clock is input only
// - answers only fixed address 1001100
// - remote 11-bit, left justified two bytes
// - local reading is 8-bit two's complement
// - results read-only, setpoints read and write
// - open diode forces +127, sets open
// - open flag alone never raises alert
// - shorted diode forces -128, open stays clear
// - pointer keeps last command byte written
// - write is address, command, one data
// - read at pointer is address then data
// - command then repeated start selects read
// - msb first, ack or nack accepted
// - both remote bytes from one conversion
// - lines low past 35 ms idle bus
// - start anywhere aborts, expects address byte
// - filter select bits D2:D1 at BFh
// - one-shot write starts conversion, reads zero
// - alert mask bit D7 blocks alert
`timescale 1ns/10ps
module tss_slave #(
  parameter int TIMEOUT_CYCLES = tss_pkg::TIMEOUT_CYC, // bus idle timeout in link cycles
  parameter logic [7:0] MFG_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DIE_REV = 8'h01 // arbitrary value
) (
  // system clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // link sampling clock
  input wire logic LINK_CLK_IN,
  // smbus pins
  input wire logic SMBCLK_IN,
  input wire logic SMBDATA_IN,
  output logic SMBDATA_OUT,
  output logic SMBDATA_OE_OUT,
  // open-drain alarm pins
  output logic ALERT_OUT,
  output logic ALERT_OE_OUT,
  output logic TCRIT_OUT,
  output logic TCRIT_OE_OUT,
  // conversion engine, system clock domain
  input wire logic CONV_DONE_IN,
  input wire logic [7:0] LOCAL_TEMP_IN,
  input wire logic [tss_pkg::REM_W-1:0] REMOTE_TEMP_IN,
  input wire logic DIODE_OPEN_IN,
  input wire logic DIODE_SHORT_IN,
  input wire logic CONV_BUSY_IN,
  output logic ONESHOT_OUT,
  // configuration, link clock domain
  output logic [7:0] CONFIG_OUT,
  output logic [7:0] CONV_RATE_OUT
);
  import tss_pkg::*;

  // ----------------------------------------
  // system clock domain state
  // ----------------------------------------
  tss_res_t res_q; // last result, held for the link to copy
  tss_res_t res_d;
  logic res_tgl_q; // flips once per finished conversion
  logic res_tgl_d;
  logic [7:0] loc_hold_q; // local reading waiting for the filter
  logic [7:0] loc_hold_d;
  logic busy_c_q;
  logic [1:0] filt_m_q; // filter select synchroniser
  logic [1:0] filt_s_q;
  logic os_m_q; // one-shot toggle synchroniser
  logic os_s_q;
  logic os_p_q;
  logic os_pulse_q;
  logic f_vld;
  logic [REM_W-1:0] f_avg;

  // ----------------------------------------
  // link clock domain state
  // ----------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q; // clock pin sync plus edge history
  logic sda_m_q, sda_s_q, sda_p_q; // data pin sync plus edge history
  logic rt_m_q, rt_s_q, rt_p_q; // result toggle sync
  logic busy_m_q, busy_s_q;
  tss_state_t st_q, st_d;
  tss_state_t nxt_q, nxt_d; // state taken after our ack bit
  logic [7:0] sh_q, sh_d; // receive and transmit shifter
  logic [3:0] cnt_q, cnt_d;
  logic oe_q, oe_d; // pulls data low while high
  logic [7:0] ptr_q, ptr_d;
  tss_regs_t regs_q, regs_d;
  logic os_tgl_q, os_tgl_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] loc_q, loc_d;
  logic [7:0] rhb_q, rhb_d;
  logic [7:0] rlb_q, rlb_d;
  logic crit_q, crit_d;
  logic alert_q, alert_d;
  logic [TO_W-1:0] to_q, to_d;
  logic [7:0] rd_byte; // byte selected by the pointer
  logic scl_rise, scl_fall, bus_start, bus_stop, res_evt;

  // ----------------------------------------
  // system domain: filter and result capture
  // ----------------------------------------
  // faulted samples bypass the filter so its history stays clean
  tss_filter u_filter (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .sample_vld_in(CONV_DONE_IN & ~DIODE_OPEN_IN & ~DIODE_SHORT_IN),
    .sample_in(REMOTE_TEMP_IN),
    .level_in(filt_s_q),
    .avg_vld_out(f_vld),
    .avg_out(f_avg)
  );

  // build the result word; the link copies it on the toggle edge
  always_comb begin
    res_d = res_q;
    res_tgl_d = res_tgl_q;
    loc_hold_d = loc_hold_q;
    if (CONV_DONE_IN) begin
      loc_hold_d = LOCAL_TEMP_IN;
    end
    if (CONV_DONE_IN && DIODE_OPEN_IN) begin
      res_d = '{local_t: LOCAL_TEMP_IN, rem_hb: OPEN_HB, rem_lb: FAULT_LB,
        open: 1'b1};
      res_tgl_d = ~res_tgl_q;
    end else if (CONV_DONE_IN && DIODE_SHORT_IN) begin
      res_d = '{local_t: LOCAL_TEMP_IN, rem_hb: SHORT_HB, rem_lb: FAULT_LB,
        open: 1'b0};
      res_tgl_d = ~res_tgl_q;
    end else if (f_vld) begin
      // left justify the 11-bit reading across two bytes
      {res_d.rem_hb, res_d.rem_lb} = {f_avg, {FRAC_PAD{1'b0}}};
      res_d.local_t = loc_hold_q;
      res_d.open = 1'b0;
      res_tgl_d = ~res_tgl_q;
    end
  end

  // system domain registers and synchronisers
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      res_q <= '{local_t: TEMP_RST, rem_hb: TEMP_RST, rem_lb: TEMP_RST, open: 1'b0};
      res_tgl_q <= 1'b0;
      loc_hold_q <= TEMP_RST;
      busy_c_q <= 1'b0;
      filt_m_q <= FILT_NONE;
      filt_s_q <= FILT_NONE;
      os_m_q <= 1'b0;
      os_s_q <= 1'b0;
      os_p_q <= 1'b0;
      os_pulse_q <= 1'b0;
    end else begin
      res_q <= res_d;
      res_tgl_q <= res_tgl_d;
      loc_hold_q <= loc_hold_d;
      busy_c_q <= CONV_BUSY_IN;
      // select bits change rarely; a mixed sample between none and level two picks level one
      filt_m_q <= regs_q.filt[FILT_SEL_HI:FILT_SEL_LO];
      filt_s_q <= filt_m_q;
      os_m_q <= os_tgl_q;
      os_s_q <= os_m_q;
      os_p_q <= os_s_q;
      os_pulse_q <= os_s_q ^ os_p_q;
    end
  end

  // ----------------------------------------
  // link domain: pin and event synchronisers
  // ----------------------------------------
  // the clock pin is only ever sampled, never driven
  always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      rt_m_q <= 1'b0;
      rt_s_q <= 1'b0;
      rt_p_q <= 1'b0;
      busy_m_q <= 1'b0;
      busy_s_q <= 1'b0;
    end else begin
      scl_m_q <= SMBCLK_IN;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= SMBDATA_IN;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      rt_m_q <= res_tgl_q;
      rt_s_q <= rt_m_q;
      rt_p_q <= rt_s_q;
      busy_m_q <= busy_c_q;
      busy_s_q <= busy_m_q;
    end
  end

  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign res_evt = rt_s_q ^ rt_p_q;

  // ----------
  // link domain: read multiplexer
  // ----------
  // unknown and write-only locations read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (ptr_q)
      CMD_LOCAL: rd_byte = loc_q;
      CMD_RHB: rd_byte = rhb_q;
      CMD_RLB: rd_byte = rlb_q;
      CMD_STAT: begin
        rd_byte = stat_q;
        rd_byte[ST_BUSY] = busy_s_q;
      end
      CMD_CFG_RD: rd_byte = regs_q.cfg;
      CMD_RATE_RD: rd_byte = regs_q.rate;
      CMD_LHS_RD: rd_byte = regs_q.lhs;
      CMD_LLS_RD: rd_byte = regs_q.lls;
      CMD_RHS_RD: rd_byte = regs_q.rhs;
      CMD_RLS_RD: rd_byte = regs_q.rls;
      CMD_RCS: rd_byte = regs_q.remote_critical_limit;
      CMD_LCS: rd_byte = regs_q.lcs;
      CMD_FILT: rd_byte = regs_q.filt;
      CMD_MFG_ID: rd_byte = MFG_ID;
      CMD_DIE_REV: rd_byte = DIE_REV;
      default: rd_byte = 8'h00; // includes one-shot
    endcase
  end

  // ----------------------------------------
  // link domain: bus engine, registers, results
  // ----------------------------------------
  always_comb begin
    logic load;
    logic clr;
    logic [7:0] set;
    load = 1'b0;
    clr = 1'b0;
    set = 8'h00;
    st_d = st_q;
    nxt_d = nxt_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    ptr_d = ptr_q;
    regs_d = regs_q;
    os_tgl_d = os_tgl_q;
    loc_d = loc_q;
    rhb_d = rhb_q;
    rlb_d = rlb_q;
    crit_d = crit_q;
    // count while either line is low
    if (scl_s_q && sda_s_q) begin
      to_d = '0;
    end else if (to_q != TO_W'(TIMEOUT_CYCLES)) begin
      to_d = to_q + 1'b1;
    end else begin
      to_d = to_q;
    end
    if (bus_start) begin
      st_d = ST_ADDR;
      cnt_d = '0;
      oe_d = 1'b0;
    end else if (bus_stop || to_q == TO_W'(TIMEOUT_CYCLES)) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_WAIT: begin
          // nothing until a start
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 1'b1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin
            cnt_d = '0;
            st_d = ST_ACK;
            oe_d = 1'b1;
            if (st_q == ST_ADDR) begin
              nxt_d = sh_q[0] ? ST_RDATA : ST_CMD;
              if (sh_q[7:1] != SLAVE_ADDR) begin
                st_d = ST_WAIT;
                oe_d = 1'b0;
              end
            end else if (st_q == ST_CMD) begin
              ptr_d = sh_q;
              nxt_d = ST_WDATA;
            end else begin
              // only one data byte per write; later bytes get no ack
              nxt_d = ST_WAIT;
              unique case (ptr_q)
                CMD_CFG_WR: regs_d.cfg = sh_q;
                CMD_RATE_WR: regs_d.rate = sh_q;
                CMD_LHS_WR: regs_d.lhs = sh_q;
                CMD_LLS_WR: regs_d.lls = sh_q;
                CMD_RHS_WR: regs_d.rhs = sh_q;
                CMD_RLS_WR: regs_d.rls = sh_q;
                CMD_RCS: regs_d.remote_critical_limit = sh_q;
                CMD_LCS: regs_d.lcs = sh_q;
                CMD_FILT: regs_d.filt = sh_q;
                CMD_ONESHOT: os_tgl_d = ~os_tgl_q;
                default: begin
                  // read-only or unused location, byte dropped
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = nxt_q;
            load = (nxt_q == ST_RDATA);
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == BYTE_BITS - 4'h1) begin
              oe_d = 1'b0; // release for the host's ack bit
              st_d = ST_HACK;
              cnt_d = '0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        ST_HACK: begin
          if (scl_rise) begin
            sh_d[0] = sda_s_q;
          end else if (scl_fall) begin
            // ack sends the same register again, nack ends quietly
            if (!sh_q[0]) begin
              load = 1'b1;
            end else begin
              st_d = ST_WAIT;
            end
          end
        end
        default: st_d = ST_IDLE; // illegal one-hot code
      endcase
    end
    if (load) begin
      st_d = ST_RDATA;
      sh_d = rd_byte;
      oe_d = ~rd_byte[7];
      cnt_d = '0;
      clr = (ptr_q == CMD_STAT);
    end
    // both remote bytes and local move together on one event
    if (res_evt) begin
      loc_d = res_q.local_t;
      rhb_d = res_q.rem_hb;
      rlb_d = res_q.rem_lb;
      set[ST_LHIGH] = $signed(res_q.local_t) > $signed(regs_q.lhs);
      set[ST_LLOW] = $signed(res_q.local_t) < $signed(regs_q.lls);
      set[ST_RHIGH] = $signed(res_q.rem_hb) > $signed(regs_q.rhs);
      set[ST_RLOW] = $signed(res_q.rem_hb) < $signed(regs_q.rls);
      set[ST_OPEN] = res_q.open;
      set[ST_RCRIT] = $signed(res_q.rem_hb) > $signed(regs_q.remote_critical_limit);
      set[ST_LCRIT] = $signed(res_q.local_t) > $signed(regs_q.lcs);
      crit_d = set[ST_RCRIT] | set[ST_LCRIT];
    end
    // a new event in the clearing cycle survives the clear
    stat_d = (clr ? 8'h00 : stat_q) | set;
    // open flag is masked out, limit flags drive the pin
    alert_d = (|(stat_q & ALERT_SRC_MASK)) & ~regs_q.cfg[CFG_ALERT_MASK_BIT];
  end

  // link domain registers
  always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= '0;
      oe_q <= 1'b0;
      ptr_q <= PTR_RST;
      regs_q <= REGS_RST;
      os_tgl_q <= 1'b0;
      stat_q <= 8'h00;
      loc_q <= TEMP_RST;
      rhb_q <= TEMP_RST;
      rlb_q <= TEMP_RST;
      crit_q <= 1'b0;
      alert_q <= 1'b0;
      to_q <= '0;
    end else begin
      st_q <= st_d;
      nxt_q <= nxt_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      ptr_q <= ptr_d;
      regs_q <= regs_d;
      os_tgl_q <= os_tgl_d;
      stat_q <= stat_d;
      loc_q <= loc_d;
      rhb_q <= rhb_d;
      rlb_q <= rlb_d;
      crit_q <= crit_d;
      alert_q <= alert_d;
      to_q <= to_d;
    end
  end

  // ----------
  // outputs
  // ----------
  // open-drain pins only ever pull low
  assign SMBDATA_OUT = 1'b0;
  assign SMBDATA_OE_OUT = oe_q;
  assign ALERT_OUT = 1'b0;
  assign ALERT_OE_OUT = alert_q;
  assign TCRIT_OUT = 1'b0;
  assign TCRIT_OE_OUT = crit_q;
  assign ONESHOT_OUT = os_pulse_q;
  assign CONFIG_OUT = regs_q.cfg;
  assign CONV_RATE_OUT = regs_q.rate;
endmodule

// File: sim/tss_slave_assertions.sv
// port checker for the smbus slave, bound into every tss_slave instance
`timescale 1ns/10ps
module tss_slave_assertions #(
  parameter int TIMEOUT_CYCLES = 200 // idle timeout in link cycles
) (
  // clocks and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic LINK_CLK_IN,
  // watched pins
  input wire logic SMBCLK_IN,
  input wire logic SMBDATA_OUT,
  input wire logic SMBDATA_OE_OUT,
  input wire logic ALERT_OUT,
  input wire logic ALERT_OE_OUT,
  input wire logic TCRIT_OUT,
  input wire logic ONESHOT_OUT,
  input wire logic [7:0] CONFIG_OUT,
  input wire logic [7:0] CONV_RATE_OUT
);
  int unsigned lo_cnt; // link cycles with bus clock held low
  // cleared by a high bus clock
  always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      lo_cnt <= 0;
    end else begin
      lo_cnt <= SMBCLK_IN ? 0 : lo_cnt + 1;
    end
  end
  sequence rel_s; // first link edge after reset release
    $rose(RSTN_IN);
  endsequence
  sequence masked_s; // mask bit seen on two edges
    CONFIG_OUT[7] [*2];
  endsequence
  default clocking @(posedge LINK_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  rst_vals_a: assert property (rel_s |-> CONFIG_OUT == 8'h00 && CONV_RATE_OUT == 8'h08)
    else $error("bad reset values");
  data_drain_a: assert property (SMBDATA_OUT == 1'b0)
    else $error("data pin driven high");
  pins_drain_a: assert property (ALERT_OUT == 1'b0 && TCRIT_OUT == 1'b0)
    else $error("alarm pin driven high");
  oe_clk_low_a: assert property ($changed(SMBDATA_OE_OUT) |-> !SMBCLK_IN)
    else $error("data moved, clock high");
  cfg_write_a: assert property ($changed(CONFIG_OUT) |-> !SMBCLK_IN)
    else $error("config moved, clock high");
  rate_write_a: assert property ($changed(CONV_RATE_OUT) |-> !SMBCLK_IN)
    else $error("rate moved, clock high");
  bus_timeout_a: assert property (lo_cnt > TIMEOUT_CYCLES + 8 |-> !SMBDATA_OE_OUT)
    else $error("no release on timeout");
  alert_mask_a: assert property (masked_s |=> !ALERT_OE_OUT)
    else $error("alert asserted while masked");
  shot_pulse_a: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    ONESHOT_OUT |=> !ONESHOT_OUT)
    else $error("long one-shot pulse");
endmodule
bind tss_slave tss_slave_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .LINK_CLK_IN(LINK_CLK_IN), .SMBCLK_IN(SMBCLK_IN),
  .SMBDATA_OUT(SMBDATA_OUT), .SMBDATA_OE_OUT(SMBDATA_OE_OUT), .ALERT_OUT(ALERT_OUT),
  .ALERT_OE_OUT(ALERT_OE_OUT), .TCRIT_OUT(TCRIT_OUT), .ONESHOT_OUT(ONESHOT_OUT),
  .CONFIG_OUT(CONFIG_OUT), .CONV_RATE_OUT(CONV_RATE_OUT));

// File: sim/tss_host.sv
// smbus host model: sole driver of the bus clock, open-drain data
`timescale 1ns/10ps
module tss_host (
  input wire logic clk_in, // paces every phase
  input wire logic sda_in, // resolved data line
  output logic scl_out, // bus clock, host only
  output logic sda_out // 1 releases the line
);
  localparam int PH = 16; // system cycles per phase
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic cyc(input int n); // also used to hold the clock low
    repeat (n) @(posedge clk_in);
  endtask
  task automatic start(); // start or repeated start
    sda_out <= 1'b1;
    cyc(PH);
    scl_out <= 1'b1;
    cyc(PH);
    sda_out <= 1'b0;
    cyc(PH);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    cyc(8);
    sda_out <= 1'b0;
    cyc(PH);
    scl_out <= 1'b1;
    cyc(PH);
    sda_out <= 1'b1;
    cyc(PH);
  endtask
  // nine bits, msb first
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      cyc(8);
      sda_out <= d[i];
      cyc(PH);
      scl_out <= 1'b1;
      cyc(PH);
      q[i] = sda_in;
      scl_out <= 1'b0;
    end
  endtask
endmodule

// File: sim/tss_slave_test.sv
// self-checking bench for the smbus slave
`timescale 1ns/10ps
module tss_slave_test;
  import tss_pkg::*;
  logic clk = 1'b0, lclk = 1'b0, rstn = 1'b0, done = 1'b0, op = 1'b0, sh = 1'b0, busy = 1'b0;
  logic [7:0] lt = 8'h00;
  logic [10:0] rt = 11'h000;
  logic scl, hsda, oe, aoe, toe, one;
  logic [7:0] cfg, rate, rd_byte, v;
  logic [8:0] q;
  logic [10:0] r;
  logic [7:0] exp_q[$]; // expected read bytes, oldest first
  // entry 0 in the lowest byte
  logic [103:0] cmds = 104'hbf201910080706050403020100;
  logic [103:0] vals = 104'h00555500004600460800000000;
  int err_total = 0, checks = 0, shots = 0;
  event rd_ev;
  wire sda = hsda & ~oe; // pull-up with wired and
  initial forever #20 clk = ~clk;
  initial begin
    #13;
    forever #80 lclk = ~lclk; // unrelated phase
  end
  tss_slave #(.TIMEOUT_CYCLES(200)) DUT (.CLK_IN(clk), .RSTN_IN(rstn), .LINK_CLK_IN(lclk),
    .SMBCLK_IN(scl), .SMBDATA_IN(sda), .SMBDATA_OUT(), .SMBDATA_OE_OUT(oe), .ALERT_OUT(),
    .ALERT_OE_OUT(aoe), .TCRIT_OUT(), .TCRIT_OE_OUT(toe), .CONV_DONE_IN(done),
    .LOCAL_TEMP_IN(lt), .REMOTE_TEMP_IN(rt), .DIODE_OPEN_IN(op), .DIODE_SHORT_IN(sh),
    .CONV_BUSY_IN(busy), .ONESHOT_OUT(one), .CONFIG_OUT(cfg), .CONV_RATE_OUT(rate));
  tss_host h (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(hsda));
  always @(posedge clk) if (one === 1'b1) shots++;
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic adr(input logic [7:0] c); // start, address with write, command
    h.start();
    h.xfer(9'h131, q);
    check("addr ack", 8'(q[0]), 8'h00);
    h.xfer({c, 1'b1}, q);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    adr(c);
    h.xfer({d, 1'b1}, q);
    h.stop();
  endtask
  task automatic rd0(input logic [7:0] e, input int n); // n bytes, last one not acked
    h.start();
    h.xfer(9'h133, q);
    for (int k = 1; k <= n; k++) begin
      exp_q.push_back(e);
      h.xfer({8'hff, k == n}, q);
      rd_byte = q[8:1];
      ->rd_ev;
    end
    h.stop();
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    adr(c);
    rd0(e, 1);
  endtask
  task automatic conv(input logic [7:0] l, input logic [10:0] x, input logic o, input logic s);
    @(posedge clk);
    {done, busy, lt, rt, op, sh} <= {2'b11, l, x, o, s};
    @(posedge clk);
    {done, busy} <= 2'b00;
    repeat (40) @(posedge clk);
  endtask
  initial forever begin
    @(rd_ev);
    check("rdata", rd_byte, exp_q.pop_front());
  end
  initial begin
    repeat (99000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    v = $urandom(89);
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    check("cfg", cfg, 8'h00);
    check("rate", rate, 8'h08);
    for (int i = 0; i < 13; i++) rd(cmds[8*i+:8], vals[8*i+:8]);
    rd0(8'h00, 2);
    $display("end of power-up test");
    for (int i = 1; i < 7; i++) begin
      h.start();
      h.xfer({8'h98 ^ (8'h01 << i), 1'b1}, q);
      check("foreign ack", 8'(q[0]), 8'h01);
      h.stop();
    end
    v = $urandom;
    wr(CMD_LHS_WR, v);
    rd(CMD_LHS_RD, v);
    wr(CMD_LOCAL, 8'h5a);
    rd(CMD_LOCAL, 8'h00);
    adr(CMD_RHS_WR);
    h.xfer({v, 1'b1}, q);
    h.xfer(9'h023, q);
    check("extra ack", 8'(q[0]), 8'h01);
    h.stop();
    rd(CMD_RHS_RD, v);
    wr(CMD_RATE_WR, 8'h05);
    check("rate", rate, 8'h05);
    $display("end of access test");
    r = 11'($urandom);
    conv(8'he7, r, 1'b0, 1'b0);
    rd(CMD_LOCAL, 8'he7);
    rd(CMD_RHB, r[10:3]);
    rd(CMD_RLB, {r[2:0], 5'h00});
    conv(8'h19, r, 1'b1, 1'b0);
    rd(CMD_RHB, 8'h7f);
    rd(CMD_RLB, 8'h00);
    check("tcrit", 8'(toe), 8'h01);
    check("alert", 8'(aoe), 8'h01);
    wr(CMD_CFG_WR, 8'h80);
    repeat (20) @(posedge clk);
    check("cfg", cfg, 8'h80);
    check("alert", 8'(aoe), 8'h00);
    conv(8'h19, r, 1'b0, 1'b1);
    rd(CMD_RHB, 8'h80);
    $display("end of conversion test");
    wr(CMD_FILT, 8'h06);
    repeat (8) conv(8'h00, 11'h000, 1'b0, 1'b0);
    conv(8'h00, 11'h040, 1'b0, 1'b0);
    rd(CMD_RHB, 8'h01);
    rd(CMD_RLB, 8'h00);
    wr(CMD_ONESHOT, 8'h33);
    repeat (30) @(posedge clk);
    check("shots", 8'(shots), 8'h01);
    rd(CMD_ONESHOT, 8'h00);
    $display("end of filter test");
    h.start();
    h.xfer(9'h133, q);
    h.cyc(100);
    check("oe held", 8'(oe), 8'h01);
    h.cyc(900);
    check("oe freed", 8'(oe), 8'h00);
    h.stop();
    rd(CMD_LHS_RD, v);
    $display("end of timeout test");
    print_verdict();
  end
endmodule
